// file: rtl/pgen_pkg.sv
// Shared constants, register map and carriers of the test pattern generator
// Assumes one 50 MHz clock, synchronous reset and an Avalon-MM register host
package pgen_pkg;
   // Register byte offsets on the Avalon port
   localparam logic [7:0]  OFS_CTRL   = 8'h64;
   localparam logic [7:0]  OFS_CFG    = 8'h68;
   localparam logic [7:0]  OFS_CUST   = 8'h6c;
   localparam logic [7:0]  OFS_DWELL  = 8'h70;
   localparam logic [7:0]  OFS_PORT   = 8'h74;
   localparam logic [7:0]  OFS_STAT   = 8'h78;
   // Reset values
   localparam logic [7:0]  CTRL_RST   = 8'h10;
   localparam logic [7:0]  CFG_RST    = 8'h00;
   localparam logic [23:0] CUST_RST   = 24'h000000;
   localparam logic [7:0]  DWELL_RST  = 8'h3c;
   // Field positions and writable bits
   localparam int          CTRL_EN    = 0;
   localparam int          CTRL_BARS  = 2;
   localparam int          CTRL_SEL   = 4;
   localparam int          SEL_W      = 4;
   localparam int          CFG_ASCRL  = 0;
   localparam int          CFG_INV    = 1;
   localparam int          CFG_TSEL   = 2;
   localparam int          CFG_SIX    = 4;
   localparam logic [7:0]  CTRL_WMASK = 8'hf5;
   localparam logic [7:0]  CFG_WMASK  = 8'h17;
   // Pattern codes
   typedef enum logic [3:0] {
      PAT_CHECK = 4'h0, PAT_WHITE, PAT_BLACK, PAT_RED, PAT_GREEN, PAT_BLUE,
      PAT_HGREY, PAT_HRED, PAT_HGREEN, PAT_HBLUE, PAT_VGREY, PAT_VRED,
      PAT_VGREEN, PAT_VBLUE, PAT_CUSTOM, PAT_VCOM
   } pgen_pat_t;
   // Ramp and bar step counts
   localparam logic [11:0] LEV_24     = 12'h100;
   localparam logic [11:0] LEV_18     = 12'h040;
   localparam logic [11:0] BAR_CNT    = 12'h008;
   localparam int          SIX_SHIFT  = 2;
   localparam logic [7:0]  SIX_MASK   = 8'hfc;
   // Bar colours {r,g,b}, bar 0 in the low bits: W Y C G M R B K
   localparam logic [23:0] BAR_RGB    = 24'h0654f7;
   // Internal timing, pixels and lines
   localparam logic [11:0] H_ACT      = 12'h280;
   localparam logic [11:0] H_TOT      = 12'h320;
   localparam logic [11:0] H_SYNC     = 12'h060;
   localparam logic [11:0] V_ACT      = 12'h1e0;
   localparam logic [11:0] V_TOT      = 12'h20d;
   localparam logic [11:0] V_SYNC     = 12'h002;

   typedef struct packed {
      logic       de;
      logic       hs;
      logic       vs;
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } pgen_pix_t;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  cfg;
      logic [23:0] cust;
      logic [7:0]  dwell;
   } pgen_bank_t;

   localparam pgen_bank_t BANK_RST = '{ctrl: CTRL_RST, cfg: CFG_RST,
                                       cust: CUST_RST, dwell: DWELL_RST};
endpackage

// file: rtl/pgen_buf.sv
// Two-entry pixel buffer between the generator and the serial link
// Assumes the receiver may stall at any time; ready is registered
`timescale 1ns/100ps
module pgen_buf (
   input  wire logic              clk_i,
   input  wire logic              srst_i,
   input  wire logic              in_valid_i,
   output logic                   in_ready_o,
   input  wire pgen_pkg::pgen_pix_t in_data_i,
   output logic                   out_valid_o,
   input  wire logic              out_ready_i,
   output pgen_pkg::pgen_pix_t    out_data_o
);
   import pgen_pkg::*;

   typedef struct packed {
      pgen_pix_t out;
      pgen_pix_t skid;
      logic      out_vld;
      logic      skid_vld;
   } pgen_buf_state_t;

   pgen_buf_state_t s;
   pgen_buf_state_t next_s;

   // Skid slot catches the word that arrives while the output stalls
   always_comb begin
      next_s = s;
      if (!s.out_vld || out_ready_i) begin
         if (s.skid_vld) begin
            next_s.out      = s.skid;
            next_s.skid_vld = 1'b0;
         end else begin
            next_s.out     = in_data_i;
            next_s.out_vld = in_valid_i;
         end
      end else if (in_valid_i && !s.skid_vld) begin
         next_s.skid     = in_data_i;
         next_s.skid_vld = 1'b1;
      end
      if (srst_i) begin
         next_s = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      s <= next_s;
   end

   assign in_ready_o  = !s.skid_vld;
   assign out_valid_o = s.out_vld;
   assign out_data_o  = s.out;
endmodule

// file: rtl/pgen_tgen.sv
// Internal video timing: free counters giving data enable and syncs
// Assumes the caller advances it only when a pixel can be accepted
`timescale 1ns/100ps
module pgen_tgen (
   input  wire logic           clk_i,
   input  wire logic           srst_i,
   input  wire logic           adv_i,
   output pgen_pkg::pgen_pix_t tg_o
);
   import pgen_pkg::*;

   typedef struct packed {
      logic [11:0] h;
      logic [11:0] v;
   } pgen_tg_state_t;

   pgen_tg_state_t s;
   pgen_tg_state_t next_s;

   // Raster walk, one pixel per accepted beat
   always_comb begin
      next_s = s;
      if (adv_i) begin
         if (s.h == H_TOT - 12'h001) begin
            next_s.h = '0;
            next_s.v = (s.v == V_TOT - 12'h001) ? '0 : s.v + 12'h001;
         end else begin
            next_s.h = s.h + 12'h001;
         end
      end
      if (srst_i) begin
         next_s = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      s <= next_s;
   end

   // Syncs sit at the tail of each line and frame, active high
   assign tg_o = '{de: (s.h < H_ACT) && (s.v < V_ACT),
                   hs: s.h >= H_TOT - H_SYNC,
                   vs: s.v >= V_TOT - V_SYNC,
                   r: 8'h00, g: 8'h00, b: 8'h00};
endmodule

// file: rtl/pgen_top.sv
// Test pattern generator control: registers, pattern engine and output path
// Assumes external video is synchronous to clk_i, one pixel per valid beat
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps
module pgen_top (
   input  wire logic                clk_i,
   input  wire logic                srst_i,
   input  wire logic [7:0]          avs_address_i,
   input  wire logic                avs_read_i,
   input  wire logic                avs_write_i,
   input  wire logic [31:0]         avs_writedata_i,
   input  wire logic [3:0]          avs_byteenable_i,
   output logic [31:0]              avs_readdata_o,
   output logic                     avs_waitrequest_o,
   input  wire logic                render_port_i,
   input  wire logic                ext_valid_i,
   output logic                     ext_ready_o,
   input  wire pgen_pkg::pgen_pix_t ext_pix_i,
   output logic                     pix_valid_o,
   input  wire logic                pix_ready_i,
   output pgen_pkg::pgen_pix_t      pix_o
);
   import pgen_pkg::*;

   typedef struct packed {
      logic             wt;
      logic [31:0]      rd;
      pgen_bank_t [1:0] bank;
      logic             port;
      logic [3:0]       apat;
      logic [7:0]       frames;
      logic [11:0]      h;
      logic [11:0]      v;
      logic [11:0]      hlen;
      logic [11:0]      vlen;
      logic [11:0]      hacc;
      logic [11:0]      vacc;
      logic [11:0]      bacc;
      logic [7:0]       hlv;
      logic [7:0]       vlv;
      logic [2:0]       bar;
      logic             de_d;
      logic             vs_d;
   } pgen_state_t;

   pgen_state_t s;
   pgen_state_t next_s;

   pgen_bank_t  bk;
   logic        en;
   logic        bars;
   logic        inv;
   logic        six;
   logic        tsel;
   logic        ascrl;
   logic [3:0]  pat;
   logic        use_int;
   logic        vld;
   logic        adv;
   logic        buf_rdy;
   logic        line_end;
   logic        frame_start;
   logic [11:0] lev;
   logic [7:0]  hl;
   logic [7:0]  vl;
   logic [23:0] col;
   logic [2:0]  bar_rgb;
   logic [19:0] bar_step;
   pgen_pix_t   tg;
   pgen_pix_t   src;
   pgen_pix_t   gen;

   // One ramp step: add the level count, carry a level per line length
   function automatic logic [19:0] ramp_step(input logic [11:0] acc,
                                             input logic [7:0]  lvl,
                                             input logic [11:0] step,
                                             input logic [11:0] len);
      logic [12:0] sum;
      sum = {1'b0, acc} + {1'b0, step};
      if ((len != 12'h000) && (sum >= {1'b0, len})) begin
         ramp_step = {12'(sum - {1'b0, len}), 8'(lvl + 8'h01)};
      end else begin
         ramp_step = {sum[11:0], lvl};
      end
   endfunction

   // Byte-lane merge for Avalon writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return m;
   endfunction

   // Settings of the port being rendered; each port keeps its own bank
   assign bk      = s.bank[render_port_i];
   assign en      = bk.ctrl[CTRL_EN];
   assign bars    = bk.ctrl[CTRL_BARS];
   assign inv     = bk.cfg[CFG_INV];
   assign six     = bk.cfg[CFG_SIX];
   assign tsel    = bk.cfg[CFG_TSEL];
   assign ascrl   = bk.cfg[CFG_ASCRL];
   assign pat     = ascrl ? s.apat : bk.ctrl[CTRL_SEL +: SEL_W];
   assign lev     = six ? LEV_18 : LEV_24;

   // Timing source; internal timing only matters while generating
   assign use_int = en && tsel;
   assign src     = use_int ? tg : ext_pix_i;
   assign vld     = use_int || ext_valid_i;
   assign adv     = vld && buf_rdy;
   assign line_end    = s.de_d && !src.de;
   assign frame_start = src.vs && !s.vs_d;

   pgen_tgen u_tgen (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .adv_i  (use_int && buf_rdy),
      .tg_o   (tg)
   );

   // Ramp levels; six-bit mode shifts the level up into the top six bits
   assign hl      = six ? 8'(s.hlv << SIX_SHIFT) : s.hlv;
   assign vl      = six ? 8'(s.vlv << SIX_SHIFT) : s.vlv;
   assign bar_rgb = BAR_RGB[3*s.bar +: 3];
   // Bar stepper; accumulator in the top bits, bar index in the low three
   assign bar_step = ramp_step(s.bacc, {5'h00, s.bar}, BAR_CNT, s.hlen);

   // Pixel colour for the current raster position
   always_comb begin
      unique case (pgen_pat_t'(pat))
         PAT_CHECK:  col = (s.h[0] ^ s.v[0]) ? 24'hffffff : 24'h000000;
         PAT_WHITE:  col = 24'hffffff;
         PAT_BLACK:  col = 24'h000000;
         PAT_RED:    col = 24'hff0000;
         PAT_GREEN:  col = 24'h00ff00;
         PAT_BLUE:   col = 24'h0000ff;
         PAT_HGREY:  col = {hl, hl, hl};
         PAT_HRED:   col = {hl, 8'h00, 8'h00};
         PAT_HGREEN: col = {8'h00, hl, 8'h00};
         PAT_HBLUE:  col = {8'h00, 8'h00, hl};
         PAT_VGREY:  col = {vl, vl, vl};
         PAT_VRED:   col = {vl, 8'h00, 8'h00};
         PAT_VGREEN: col = {8'h00, vl, 8'h00};
         PAT_VBLUE:  col = {8'h00, 8'h00, vl};
         PAT_CUSTOM: col = bk.cust;
         PAT_VCOM:   col = (s.h[0] ^ s.v[0]) ? 24'hff00ff : 24'h00ff00;
      endcase
      // Bars override the fixed pattern
      if (bars) begin
         col = {{8{bar_rgb[2]}}, {8{bar_rgb[1]}}, {8{bar_rgb[0]}}};
      end
      if (inv) begin
         col = ~col;
      end
      // Low bits cleared so an 18-bit panel sees clean levels
      if (six) begin
         col = col & {SIX_MASK, SIX_MASK, SIX_MASK};
      end
      gen = src;
      if (en) begin
         {gen.r, gen.g, gen.b} = col;
      end
   end

   pgen_buf u_buf (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .in_valid_i  (adv),
      .in_ready_o  (buf_rdy),
      .in_data_i   (gen),
      .out_valid_o (pix_valid_o),
      .out_ready_i (pix_ready_i),
      .out_data_o  (pix_o)
   );

   // All state: register file, raster counters, ramps, auto-advance
   always_comb begin
      next_s = s;
      // Bus: take on wt high, answer one cycle later with wt low
      if (s.wt && (avs_read_i || avs_write_i)) begin
         next_s.wt = 1'b0;
         if (avs_read_i) begin
            unique case (avs_address_i)
               OFS_CTRL:  next_s.rd = {24'h000000, s.bank[s.port].ctrl};
               OFS_CFG:   next_s.rd = {24'h000000, s.bank[s.port].cfg};
               OFS_CUST:  next_s.rd = {8'h00, s.bank[s.port].cust};
               OFS_DWELL: next_s.rd = {24'h000000, s.bank[s.port].dwell};
               OFS_PORT:  next_s.rd = {31'h00000000, s.port};
               OFS_STAT:  next_s.rd = {16'h0000, s.frames, 3'h0, en, pat};
               default:   next_s.rd = 32'h00000000;
            endcase
         end
      end else if (!s.wt) begin
         next_s.wt = 1'b1;
         if (avs_write_i) begin
            unique case (avs_address_i)
               OFS_CTRL: begin
                  next_s.bank[s.port].ctrl = CTRL_WMASK & 8'(merge(
                     {24'h000000, s.bank[s.port].ctrl}, avs_writedata_i,
                     avs_byteenable_i));
               end
               OFS_CFG: begin
                  next_s.bank[s.port].cfg = CFG_WMASK & 8'(merge(
                     {24'h000000, s.bank[s.port].cfg}, avs_writedata_i,
                     avs_byteenable_i));
               end
               OFS_CUST: begin
                  next_s.bank[s.port].cust = 24'(merge(
                     {8'h00, s.bank[s.port].cust}, avs_writedata_i,
                     avs_byteenable_i));
               end
               OFS_DWELL: begin
                  next_s.bank[s.port].dwell = 8'(merge(
                     {24'h000000, s.bank[s.port].dwell}, avs_writedata_i,
                     avs_byteenable_i));
               end
               OFS_PORT: begin
                  next_s.port = avs_byteenable_i[0] ? avs_writedata_i[0] : s.port;
               end
               default: begin
               end
            endcase
         end
      end

      // Raster tracking follows whichever timing drives the link
      if (adv) begin
         next_s.de_d = src.de;
         next_s.vs_d = src.vs;
         if (src.de) begin
            next_s.h = s.h + 12'h001;
            {next_s.hacc, next_s.hlv} = ramp_step(s.hacc, s.hlv, lev, s.hlen);
            // Bar index steps once per eighth of the measured width
            next_s.bacc = bar_step[19:8];
            next_s.bar  = bar_step[2:0];
         end
         // Line end: last width becomes the ramp length of the next line
         if (line_end) begin
            next_s.hlen = s.h;
            next_s.h    = '0;
            next_s.hacc = '0;
            next_s.hlv  = '0;
            next_s.bacc = '0;
            next_s.bar  = '0;
            next_s.v    = s.v + 12'h001;
            {next_s.vacc, next_s.vlv} = ramp_step(s.vacc, s.vlv, lev, s.vlen);
         end
         // Frame start: height latched, dwell counter steps in auto mode, else clears
         if (frame_start) begin
            next_s.vlen = s.v;
            next_s.v    = '0;
            next_s.vacc = '0;
            next_s.vlv  = '0;
            if (ascrl) begin
               if (9'(s.frames) + 9'h001 >= {1'b0, bk.dwell}) begin
                  next_s.frames = '0;
                  next_s.apat   = s.apat + 4'h1;
               end else begin
                  next_s.frames = s.frames + 8'h01;
               end
            end else begin
               next_s.frames = '0;
            end
         end
      end

      if (srst_i) begin
         next_s      = '0;
         next_s.wt   = 1'b1;
         next_s.bank = {BANK_RST, BANK_RST};
      end
   end

   always_ff @(posedge clk_i) begin
      s <= next_s;
   end

   // Outputs straight from state
   assign avs_waitrequest_o = s.wt;
   assign avs_readdata_o    = s.rd;
   assign ext_ready_o       = buf_rdy;

   // Checks on output pixels and pattern state
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   sequence frame_start_s;
      adv && frame_start;
   endsequence

   sequence dwell_done_s;
      ascrl && (9'(s.frames) + 9'h001 >= {1'b0, bk.dwell});
   endsequence

   property advance_p;
      frame_start_s ##0 dwell_done_s |=> s.apat == 4'($past(s.apat) + 4'h1);
   endproperty

   // A beat taken into a free output slot shows up on the next cycle
   enable_pass_a: assert property (
      adv && !en && (!pix_valid_o || pix_ready_i) |=> pix_valid_o && pix_o == $past(src))
      else $error("disabled video altered");
   select_src_a: assert property (
      en && !ascrl && !bars && !inv && !six && bk.ctrl[CTRL_SEL +: SEL_W] == PAT_RED
      |-> {gen.r, gen.g, gen.b} == 24'hff0000)
      else $error("red select wrong");
   // Turning auto mode on or switching banks may legally move the pattern
   auto_ignore_a: assert property (
      ascrl && $stable(ascrl) && $stable(s.apat) && $stable(render_port_i) |-> $stable(pat))
      else $error("select field leaked");
   ramp_restart_a: assert property (
      adv && line_end |=> s.hlv == 8'h00 && s.h == 12'h000)
      else $error("ramp not restarted");
   white_field_a: assert property (
      en && !bars && !inv && !six && pat == PAT_WHITE |-> {gen.r, gen.g, gen.b} == 24'hffffff)
      else $error("white wrong");
   hred_ramp_a: assert property (
      en && !bars && !inv && !six && pat == PAT_HRED |-> gen.r == s.hlv && gen.g == 8'h00)
      else $error("red ramp wrong");
   vblue_ramp_a: assert property (
      en && !bars && inv && !six && pat == PAT_VBLUE |-> gen.b == ~s.vlv && gen.r == 8'hff)
      else $error("yellow ramp wrong");
   vgrey_code_a: assert property (
      en && !bars && !inv && !six && pat == PAT_VGREY |-> gen.g == s.vlv)
      else $error("vertical grey wrong");
   custom_fill_a: assert property (
      en && !bars && !inv && !six && pat == PAT_CUSTOM |-> {gen.r, gen.g, gen.b} == bk.cust)
      else $error("custom colour wrong");
   vcom_alt_a: assert property (
      en && !bars && !inv && !six && pat == PAT_VCOM
      |-> gen.g == ((s.h[0] ^ s.v[0]) ? 8'h00 : 8'hff))
      else $error("vcom wrong");
   bar_first_a: assert property (
      en && bars && !inv && !six && s.bar == 3'h0 |-> {gen.r, gen.g, gen.b} == 24'hffffff)
      else $error("bar order wrong");
   invert_all_a: assert property (
      en && bars && inv && !six && s.bar == 3'h0 |-> {gen.r, gen.g, gen.b} == 24'h000000)
      else $error("inversion missing");
   auto_step_a: assert property (
      advance_p)
      else $error("no pattern advance");
   six_bit_a: assert property (
      en && six |-> gen.r[1:0] == 2'b00 && gen.b[1:0] == 2'b00)
      else $error("low bits set");
   // Internal timing makes its own beats, with no external video at all
   timing_src_a: assert property (
      en && tsel && buf_rdy |=> pix_valid_o)
      else $error("timing source wrong");
endmodule

// file: test/pgen_sink_model.sv
// Behavioural sink standing in for the serial link transmit path
// Assumes the bench raises stall_i to hold off acceptance
`timescale 1ns/100ps
module pgen_sink_model (
   input  wire logic                clk_i,
   input  wire logic                srst_i,
   input  wire logic                stall_i,
   input  wire logic                valid_i,
   output logic                     ready_o,
   input  wire pgen_pkg::pgen_pix_t data_i,
   output pgen_pkg::pgen_pix_t      last_o,
   output int                       cnt_o
);
   import pgen_pkg::*;
   // Registered ready, so a stall bites a cycle late as on a real link
   always_ff @(posedge clk_i) begin
      ready_o <= !srst_i && !stall_i;
      if (srst_i) begin
         cnt_o <= 0;
      end else if (valid_i && ready_o) begin
         cnt_o  <= cnt_o + 1;
         last_o <= data_i;
      end
   end
endmodule

// file: test/testbench.sv
// Self-checking bench of the test pattern generator control
// Assumes pgen_top and the sink model; one 50 MHz clock
`timescale 1ns/100ps
module testbench;
   import pgen_pkg::*;
   logic        clk_i = 1'b0, srst_i = 1'b1, rd = 1'b0, wr = 1'b0, wait_o;
   logic        rport = 1'b0, evld = 1'b0, erdy, pvld, prdy, stall = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [3:0]  p;
   pgen_pix_t   epix = '0, ppix, last;
   int          error_cnt, samples_checked, cnt, cyc, n, c0;
   logic [23:0] col [6] = '{24'h0, 24'hffffff, 24'h0, 24'hff0000, 24'h00ff00, 24'h0000ff};

   pgen_top pgen_top_i (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
      .render_port_i(rport), .ext_valid_i(evld), .ext_ready_o(erdy),
      .ext_pix_i(epix), .pix_valid_o(pvld), .pix_ready_i(prdy), .pix_o(ppix));
   pgen_sink_model pgen_sink_model_i (.clk_i(clk_i), .srst_i(srst_i), .stall_i(stall),
      .valid_i(pvld), .ready_o(prdy), .data_i(ppix), .last_o(last), .cnt_o(cnt));

   // Free-running clock
   initial begin
      forever #10 clk_i = ~clk_i;
   end

   task automatic tally_and_finish;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
      end
   endtask

   // Avalon access held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdat <= d;
      do @(posedge clk_i); while (wait_o !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   // One pixel in, active by default, then a bounded wait for the sink to take it
   task automatic push(input logic [23:0] rgb, input logic [2:0] f = 3'b100);
      c0 = cnt;
      @(posedge clk_i);
      evld <= 1'b1;
      epix <= {f, rgb};
      do @(posedge clk_i); while (erdy !== 1'b1);
      evld <= 1'b0;
      for (int i = 0; i < 20 && cnt == c0; i++) @(posedge clk_i);
   endtask

   task automatic t_regs;
      bus(0, OFS_CTRL, 0);
      check(q, 32'h10);
      bus(0, OFS_DWELL, 0);
      check(q, 32'h3c);
      bus(0, 8'h00, 0);
      check(q, 32'h0);
      bus(1, OFS_CTRL, 32'hff);
      bus(0, OFS_CTRL, 0);
      check(q, 32'hf5);
   endtask

   task automatic t_pass;
      bus(1, OFS_CTRL, 32'h30);
      push(24'ha5c33c);
      check({8'h0, last[23:0]}, 32'ha5c33c);
   endtask

   // Every fixed full-field code, plain and inverted; custom inverted only
   task automatic t_fields;
      for (int v = 0; v < 2; v++) begin
         bus(1, OFS_CFG, 32'(v * 2));
         for (int c = 1; c < 6; c++) begin
            bus(1, OFS_CTRL, 32'(c * 16 + 1));
            push(24'h5a5a5a);
            check({8'h0, last[23:0]}, {8'h0, col[c] ^ {24{v[0]}}});
         end
      end
      bus(1, OFS_CUST, 32'h123456);
      bus(1, OFS_CTRL, 32'he1);
      push(24'h0);
      check({8'h0, last[23:0]}, 32'hedcba9);
      bus(1, OFS_CTRL, 32'h15);
      push(24'h0);
      check({8'h0, last[23:0]}, 32'h0);
      bus(1, OFS_CFG, 32'h10);
      bus(1, OFS_CTRL, 32'h11);
      push(24'h0);
      check({8'h0, last[23:0]}, 32'hfcfcfc);
      bus(1, OFS_CFG, 0);
   endtask

   task automatic t_auto;
      bus(1, OFS_CTRL, 32'h21);
      bus(1, OFS_CFG, 32'h01);
      bus(0, OFS_STAT, 0);
      p = q[3:0];
      bus(1, OFS_CTRL, 32'h91);
      bus(0, OFS_STAT, 0);
      check({28'h0, q[3:0]}, {28'h0, p});
      // Two frame starts by the vs flag, dwell of two frames
      bus(1, OFS_DWELL, 32'h02);
      push(24'h0, 3'b001);
      bus(0, OFS_STAT, 0);
      check({24'h0, q[15:8]}, 32'h1);
      push(24'h0, 3'b000);
      push(24'h0, 3'b001);
      bus(0, OFS_STAT, 0);
      check({28'h0, q[3:0]}, {28'h0, 4'(p + 4'h1)});
      bus(1, OFS_CFG, 0);
   endtask

   task automatic t_bank;
      bus(1, OFS_PORT, 1);
      bus(1, OFS_CTRL, 32'h21);
      bus(1, OFS_PORT, 0);
      bus(1, OFS_CTRL, 32'h11);
      rport <= 1'b1;
      push(24'h777777);
      check({8'h0, last[23:0]}, 32'h0);
      rport <= 1'b0;
      push(24'h777777);
      check({8'h0, last[23:0]}, 32'hffffff);
   endtask

   // Stalled sink: the buffer must refuse, then deliver every beat taken
   task automatic t_stall;
      bus(1, OFS_CTRL, 32'h00);
      c0 = cnt;
      n = 0;
      stall <= 1'b1;
      evld <= 1'b1;
      epix <= {3'b100, 24'h3c3c3c};
      repeat (8) begin
         @(posedge clk_i);
         if (erdy === 1'b1) n++;
      end
      evld <= 1'b0;
      stall <= 1'b0;
      repeat (20) @(posedge clk_i);
      check(32'(n < 8), 32'h1);
      check(32'(cnt - c0), 32'(n));
      check({8'h0, last[23:0]}, 32'h3c3c3c);
   endtask

   task automatic t_timing;
      bus(1, OFS_CFG, 32'h04);
      c0 = cnt;
      bus(1, OFS_CTRL, 32'h11);
      repeat (50) @(posedge clk_i);
      check(32'(cnt - c0 > 30), 32'h1);
      check({8'h0, last[23:0]}, 32'hffffff);
      bus(1, OFS_CTRL, 32'h10);
      bus(1, OFS_CFG, 0);
   endtask

   // Reset, then the scenarios in turn
   initial begin
      repeat (10) @(posedge clk_i);
      srst_i <= 1'b0;
      t_regs();
      t_pass();
      t_fields();
      t_auto();
      t_bank();
      t_stall();
      t_timing();
      tally_and_finish();
   end
endmodule
